// ---- design/lock_monitor_map.vh ----
// Purpose: register offsets, field positions, reset values and threshold codes of the lock monitor
// Assumes: byte-wide registers at byte addresses on a 16-bit register address
// Notes:   definitions only
`ifndef LOCK_MONITOR_MAP_VH
`define LOCK_MONITOR_MAP_VH

// register offsets
`define LM_ADDR_LIVE_STATUS     16'h000E
`define LM_ADDR_STICKY_FLAG     16'h0013
`define LM_ADDR_IRQ_MASK        16'h0019
`define LM_ADDR_FAST_ENABLE     16'h0092
`define LM_ADDR_SET_THRESHOLD   16'h009E
`define LM_ADDR_CLEAR_THRESHOLD 16'h00A0
`define LM_ADDR_TIMER_ENABLE    16'h00A2
`define LM_ADDR_DELAY_BYTE0     16'h00A9
`define LM_ADDR_DELAY_BYTE1     16'h00AA
`define LM_ADDR_DELAY_BYTE2     16'h00AB
`define LM_ADDR_DELAY_BYTE3     16'h00AC

// field positions
`define LM_FLAG_BIT             1
`define LM_THR_MSB              7
`define LM_THR_LSB              4
`define LM_DELAY_TOP_MSB        4
`define LM_DELAY_W              29

// reset values
`define LM_RST_IRQ_MASK         1'h0
`define LM_RST_FAST_ENABLE      1'h1
`define LM_RST_SET_THRESHOLD    4'h2
`define LM_RST_CLEAR_THRESHOLD  4'h0
`define LM_RST_TIMER_ENABLE     1'h0
`define LM_RST_DELAY            29'h0000000

// width of the clear delay time base counter; one delay step is 256 reference cycles
`define LM_DELAY_UNIT_W         8
// fast comparator threshold as a multiple of the set threshold
`define LM_FAST_FACTOR          64'h0000000000000064
// error scale: thresholds are held in tenths of a ppm
`define LM_PPM_SCALE            64'h0000000000989680

// threshold codes in tenths of a ppm, 1-3-10 series from 0.1 ppm
`define LM_THR_0                64'h0000000000000001
`define LM_THR_1                64'h0000000000000003
`define LM_THR_2                64'h000000000000000A
`define LM_THR_3                64'h000000000000001E
`define LM_THR_4                64'h0000000000000064
`define LM_THR_5                64'h000000000000012C
`define LM_THR_6                64'h00000000000003E8
`define LM_THR_7                64'h0000000000000BB8
`define LM_THR_8                64'h0000000000002710
`define LM_THR_9                64'h0000000000007530
`define LM_THR_10               64'h00000000000186A0
// set codes start at 1 ppm, two steps above the clear series
`define LM_SET_CODE_OFFSET      4'h2
// highest set code with its own threshold
`define LM_SET_CODE_MAX         4'h8

`endif

// ---- design/lock_loss_monitor.v ----
// Purpose: loss-of-lock monitor comparing input and feedback clock rates, with hysteresis and clear delay
// Assumes: both monitored clocks well below half of clk_i; they are sampled as asynchronous pins
// Notes:   byte registers at their own offsets through a simple strobe port
//
// How it works
// - live loss-of-lock status rises whenever the loop loses its input clock.
// - lock is judged from input versus feedback clock frequency difference.
// - dedicated loss-of-lock pin always follows the live, non-sticky state.
// - live status bit reads 0 when locked, 1 when not locked.
// - sticky flag holds a fault; writing 0 clears it only once live status dropped.
// - mask bit gates sticky flag onto interrupt; 0 allows, 1 ignores.
// - 4-bit set threshold picks 1 to 10000 ppm in 1-3-10 steps.
// - 4-bit clear threshold picks 0.1 ppm upward in 1-3-10 steps.
// - separate set and clear comparators give hysteresis against chatter.
// - fast comparator at hundred times set threshold asserts after short measurement.
// - fast-assert enable bit, default 1, switches fast comparator on or off.
// - with timer on, loss stays asserted for programmed delay after clear condition.
// - clear delay is 29 bits spread over four consecutive byte registers.
// - timer enable 1 applies the clear delay, 0 bypasses it.
// - asserted loss of lock also drives the fastlock request.
// - interrupt goes inactive only after software clears the sticky flag or sets the mask bit.
`timescale 1ns/1ps
`include "lock_monitor_map.vh"
`default_nettype none

module lock_loss_monitor #(
    parameter integer CNT_W            = 24,
    parameter integer SLOW_WIN_CYCLES  = 1048576,
    parameter integer FAST_WIN_CYCLES  = 8192
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        in_clk_i,
    input  wire        fb_clk_i,
    input  wire [15:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         lock_loss_status_o,
    output reg         lock_loss_pin_n_o,
    output reg         lock_loss_sticky_o,
    output reg         interrupt_out_n_o,
    output reg         fastlock_req_o
);

    localparam [1:0] ST_LOCKED  = 2'h1;
    localparam [1:0] ST_LOSS    = 2'h2;

    // configuration
    reg                    irq_mask_reg;
    reg                    fast_en_reg;
    reg  [3:0]             set_thr_reg;
    reg  [3:0]             clr_thr_reg;
    reg                    timer_en_reg;
    reg  [`LM_DELAY_W-1:0] delay_reg;

    // three-stage pin samplers, index 0 input clock, 1 feedback clock
    reg  [1:0]             samp1_reg;
    reg  [1:0]             samp2_reg;
    reg  [1:0]             samp3_reg;
    reg  [1:0]             stable_reg;
    wire [1:0]             rise;
    wire [1:0]             pins = {fb_clk_i, in_clk_i};

    always @(posedge clk_i) begin
        if (rst_i) begin
            samp1_reg  <= 2'h0;
            samp2_reg  <= 2'h0;
            samp3_reg  <= 2'h0;
            stable_reg <= 2'h0;
        end else begin
            samp1_reg  <= pins;
            samp2_reg  <= samp1_reg;
            samp3_reg  <= samp2_reg;
            stable_reg <= (samp2_reg & samp3_reg) | (stable_reg & (samp2_reg | samp3_reg));
        end
    end
    assign rise = samp2_reg & samp3_reg & ~stable_reg;

    // measurement windows: index 0 slow (set/clear), index 1 fast
    reg  [31:0]            win_cnt_reg [0:1];
    reg  [CNT_W-1:0]       in_cnt_reg  [0:1];
    reg  [CNT_W-1:0]       fb_cnt_reg  [0:1];
    wire [1:0]             win_end;

    genvar w;
    generate
        for (w = 0; w < 2; w = w + 1) begin : g_win
            localparam [31:0] LEN = (w == 0) ? SLOW_WIN_CYCLES : FAST_WIN_CYCLES;
            assign win_end[w] = (win_cnt_reg[w] == LEN - 32'h1);
            always @(posedge clk_i) begin
                if (rst_i || win_end[w]) begin
                    win_cnt_reg[w] <= 32'h0;
                    in_cnt_reg[w]  <= {CNT_W{1'b0}};
                    fb_cnt_reg[w]  <= {CNT_W{1'b0}};
                end else begin
                    win_cnt_reg[w] <= win_cnt_reg[w] + 32'h1;
                    in_cnt_reg[w]  <= in_cnt_reg[w] + {{(CNT_W-1){1'b0}}, rise[0]};
                    fb_cnt_reg[w]  <= fb_cnt_reg[w] + {{(CNT_W-1){1'b0}}, rise[1]};
                end
            end
        end
    endgenerate

    function [63:0] thr_tenth_ppm;
        input [3:0] code;
        begin
            case (code)
                4'h0:    thr_tenth_ppm = `LM_THR_0;
                4'h1:    thr_tenth_ppm = `LM_THR_1;
                4'h2:    thr_tenth_ppm = `LM_THR_2;
                4'h3:    thr_tenth_ppm = `LM_THR_3;
                4'h4:    thr_tenth_ppm = `LM_THR_4;
                4'h5:    thr_tenth_ppm = `LM_THR_5;
                4'h6:    thr_tenth_ppm = `LM_THR_6;
                4'h7:    thr_tenth_ppm = `LM_THR_7;
                4'h8:    thr_tenth_ppm = `LM_THR_8;
                4'h9:    thr_tenth_ppm = `LM_THR_9;
                default: thr_tenth_ppm = `LM_THR_10;
            endcase
        end
    endfunction

    // relative error compare without a divider: |in-fb|*1e7 against thr*in
    function err_above;
        input [CNT_W-1:0] a;
        input [CNT_W-1:0] b;
        input [63:0]      thr;
        reg   [63:0]      diff;
        begin
            diff = (a > b) ? {{(64-CNT_W){1'b0}}, a - b} : {{(64-CNT_W){1'b0}}, b - a};
            err_above = (diff * `LM_PPM_SCALE) > (thr * {{(64-CNT_W){1'b0}}, a});
        end
    endfunction

    // codes past the top choice saturate instead of wrapping into the clear series
    wire [63:0] set_thr  = (set_thr_reg > `LM_SET_CODE_MAX) ? `LM_THR_10
                         : thr_tenth_ppm(set_thr_reg + `LM_SET_CODE_OFFSET);
    wire [63:0] clr_thr  = thr_tenth_ppm(clr_thr_reg);
    wire [63:0] fast_thr = set_thr * `LM_FAST_FACTOR;

    // two independent comparators on the slow window
    wire set_hit   = win_end[0] && err_above(in_cnt_reg[0], fb_cnt_reg[0], set_thr);
    wire clr_met   = win_end[0] && !err_above(in_cnt_reg[0], fb_cnt_reg[0], clr_thr);
    wire clr_lost  = win_end[0] && !clr_met;
    wire fast_hit  = fast_en_reg && win_end[1] && err_above(in_cnt_reg[1], fb_cnt_reg[1], fast_thr);

    // lock state and clear delay
    reg  [1:0]                   state_reg;
    reg  [1:0]                   state_next;
    reg                          clr_ok_reg;
    reg                          clr_ok_next;
    reg  [`LM_DELAY_UNIT_W-1:0]  unit_cnt_reg;
    reg  [`LM_DELAY_UNIT_W-1:0]  unit_cnt_next;
    reg  [`LM_DELAY_W-1:0]       delay_cnt_reg;
    reg  [`LM_DELAY_W-1:0]       delay_cnt_next;
    wire                         unit_tick = &unit_cnt_reg;

    always @* begin
        state_next     = state_reg;
        clr_ok_next    = clr_ok_reg;
        unit_cnt_next  = unit_cnt_reg;
        delay_cnt_next = delay_cnt_reg;
        case (state_reg)
            ST_LOCKED: begin
                if (set_hit || fast_hit) begin
                    state_next     = ST_LOSS;
                    clr_ok_next    = 1'b0;
                    unit_cnt_next  = {`LM_DELAY_UNIT_W{1'b0}};
                    delay_cnt_next = {`LM_DELAY_W{1'b0}};
                end
            end
            ST_LOSS: begin
                if (set_hit || fast_hit || clr_lost) begin
                    // restart when clear condition slips away
                    clr_ok_next    = 1'b0;
                    unit_cnt_next  = {`LM_DELAY_UNIT_W{1'b0}};
                    delay_cnt_next = {`LM_DELAY_W{1'b0}};
                end else if (clr_met && !timer_en_reg) begin
                    state_next  = ST_LOCKED;
                    clr_ok_next = 1'b0;
                end else if (clr_met || clr_ok_reg) begin
                    clr_ok_next = 1'b1;
                    if (!timer_en_reg || delay_cnt_reg >= delay_reg) begin
                        state_next  = ST_LOCKED;
                        clr_ok_next = 1'b0;
                    end else begin
                        unit_cnt_next = unit_cnt_reg + {{(`LM_DELAY_UNIT_W-1){1'b0}}, 1'b1};
                        if (unit_tick) begin
                            delay_cnt_next = delay_cnt_reg + {{(`LM_DELAY_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
            end
            default: begin
                state_next = ST_LOSS;
            end
        endcase
    end

    // loss is reported from reset until the first clean measurement
    wire loss_next = (state_next != ST_LOCKED);

    // register writes; a sticky set wins over a same-cycle clear
    wire wr_flag = reg_wr_i && (reg_addr_i == `LM_ADDR_STICKY_FLAG) && !reg_wdata_i[`LM_FLAG_BIT];
    reg  sticky_next;
    always @* begin
        sticky_next = lock_loss_sticky_o;
        if (wr_flag && !lock_loss_status_o) begin
            sticky_next = 1'b0;
        end
        if (loss_next) begin
            sticky_next = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg          <= ST_LOSS;
            clr_ok_reg         <= 1'b0;
            unit_cnt_reg       <= {`LM_DELAY_UNIT_W{1'b0}};
            delay_cnt_reg      <= {`LM_DELAY_W{1'b0}};
            lock_loss_status_o <= 1'b1;
            lock_loss_pin_n_o  <= 1'b0;
            lock_loss_sticky_o <= 1'b1;
            interrupt_out_n_o  <= 1'b1;
            fastlock_req_o     <= 1'b1;
        end else begin
            state_reg          <= state_next;
            clr_ok_reg         <= clr_ok_next;
            unit_cnt_reg       <= unit_cnt_next;
            delay_cnt_reg      <= delay_cnt_next;
            lock_loss_status_o <= loss_next;
            lock_loss_pin_n_o  <= !loss_next;
            lock_loss_sticky_o <= sticky_next;
            interrupt_out_n_o  <= !(sticky_next && !irq_mask_reg);
            fastlock_req_o     <= loss_next;
        end
    end

    // configuration registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= `LM_RST_IRQ_MASK;
            fast_en_reg  <= `LM_RST_FAST_ENABLE;
            set_thr_reg  <= `LM_RST_SET_THRESHOLD;
            clr_thr_reg  <= `LM_RST_CLEAR_THRESHOLD;
            timer_en_reg <= `LM_RST_TIMER_ENABLE;
            delay_reg    <= `LM_RST_DELAY;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `LM_ADDR_IRQ_MASK:        irq_mask_reg <= reg_wdata_i[`LM_FLAG_BIT];
                `LM_ADDR_FAST_ENABLE:     fast_en_reg  <= reg_wdata_i[`LM_FLAG_BIT];
                `LM_ADDR_SET_THRESHOLD:   set_thr_reg  <= reg_wdata_i[`LM_THR_MSB:`LM_THR_LSB];
                `LM_ADDR_CLEAR_THRESHOLD: clr_thr_reg  <= reg_wdata_i[`LM_THR_MSB:`LM_THR_LSB];
                `LM_ADDR_TIMER_ENABLE:    timer_en_reg <= reg_wdata_i[`LM_FLAG_BIT];
                // four byte lanes of the delay
                `LM_ADDR_DELAY_BYTE0:     delay_reg[7:0]   <= reg_wdata_i;
                `LM_ADDR_DELAY_BYTE1:     delay_reg[15:8]  <= reg_wdata_i;
                `LM_ADDR_DELAY_BYTE2:     delay_reg[23:16] <= reg_wdata_i;
                `LM_ADDR_DELAY_BYTE3:     delay_reg[28:24] <= reg_wdata_i[`LM_DELAY_TOP_MSB:0];
                default: begin
                end
            endcase
        end
    end

    // read data, registered; unmapped offsets read zero
    reg [7:0] rdata_next;
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            `LM_ADDR_LIVE_STATUS:     rdata_next[`LM_FLAG_BIT] = lock_loss_status_o;
            `LM_ADDR_STICKY_FLAG:     rdata_next[`LM_FLAG_BIT] = lock_loss_sticky_o;
            `LM_ADDR_IRQ_MASK:        rdata_next[`LM_FLAG_BIT] = irq_mask_reg;
            `LM_ADDR_FAST_ENABLE:     rdata_next[`LM_FLAG_BIT] = fast_en_reg;
            `LM_ADDR_SET_THRESHOLD:   rdata_next[`LM_THR_MSB:`LM_THR_LSB] = set_thr_reg;
            `LM_ADDR_CLEAR_THRESHOLD: rdata_next[`LM_THR_MSB:`LM_THR_LSB] = clr_thr_reg;
            `LM_ADDR_TIMER_ENABLE:    rdata_next[`LM_FLAG_BIT] = timer_en_reg;
            `LM_ADDR_DELAY_BYTE0:     rdata_next = delay_reg[7:0];
            `LM_ADDR_DELAY_BYTE1:     rdata_next = delay_reg[15:8];
            `LM_ADDR_DELAY_BYTE2:     rdata_next = delay_reg[23:16];
            `LM_ADDR_DELAY_BYTE3:     rdata_next[`LM_DELAY_TOP_MSB:0] = delay_reg[28:24];
            default:                  rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

endmodule // lock_loss_monitor

`default_nettype wire

// ---- dv/lock_loss_monitor_properties.sv ----
// Purpose: port-level assertions for the loss-of-lock monitor
// Assumes: map header on the include path
// Notes:   bound to every monitor instance
`timescale 1ns/1ps
`default_nettype none
`include "lock_monitor_map.vh"
module lock_loss_monitor_properties (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        lock_loss_status_o,
    input wire logic        lock_loss_pin_n_o,
    input wire logic        lock_loss_sticky_o,
    input wire logic        interrupt_out_n_o,
    input wire logic        fastlock_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic clr_wr;
    assign clr_wr = reg_wr_i && reg_addr_i == `LM_ADDR_STICKY_FLAG && !reg_wdata_i[`LM_FLAG_BIT];
    pin_follows_status_a: assert property (lock_loss_pin_n_o == !lock_loss_status_o)
        else $error("loss pin is not the inverse of live status");
    fastlock_follows_a: assert property (fastlock_req_o == lock_loss_status_o)
        else $error("fastlock request differs from live status");
    sticky_catches_loss_a: assert property ($rose(lock_loss_status_o) |-> ##[0:1] lock_loss_sticky_o)
        else $error("sticky flag missed a loss event");
    sticky_holds_a: assert property (lock_loss_sticky_o && !clr_wr |=> lock_loss_sticky_o)
        else $error("sticky flag dropped without a clear write");
    sticky_refused_a: assert property (lock_loss_sticky_o && lock_loss_status_o |=> lock_loss_sticky_o)
        else $error("sticky flag cleared while loss still live");
    sticky_clears_a: assert property (clr_wr && !lock_loss_status_o |=> !lock_loss_sticky_o || lock_loss_status_o)
        else $error("sticky flag ignored a legal clear write");
    irq_release_a: assert property ($rose(interrupt_out_n_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("interrupt released without a software write");
    status_read_a: assert property (reg_rd_i && reg_addr_i == `LM_ADDR_LIVE_STATUS
        |=> reg_rdata_o == {6'h00, $past(lock_loss_status_o), 1'h0})
        else $error("live status read returned a wrong byte");
    sticky_read_a: assert property (reg_rd_i && reg_addr_i == `LM_ADDR_STICKY_FLAG
        |=> reg_rdata_o[1] == $past(lock_loss_sticky_o))
        else $error("sticky read returned a wrong bit");
    rdata_holds_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule // lock_loss_monitor_properties
bind lock_loss_monitor lock_loss_monitor_properties chk (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .lock_loss_status_o(lock_loss_status_o), .lock_loss_pin_n_o(lock_loss_pin_n_o),
    .lock_loss_sticky_o(lock_loss_sticky_o), .interrupt_out_n_o(interrupt_out_n_o),
    .fastlock_req_o(fastlock_req_o));
`default_nettype wire

// ---- dv/lock_loss_monitor_bench.sv ----
// Purpose: self-checking bench for the loss-of-lock monitor
// Assumes: shortened windows, 20 percent error when unlocked
// Notes:   fb mirrors in exactly while locked so counts match
`timescale 1ns/1ps
`default_nettype none
`include "lock_monitor_map.vh"
module lock_loss_monitor_bench;
    localparam int SLOW = 4096;
    localparam int FAST = 256;
    logic        clk_i = 0, rst_i = 1, in_clk_i = 0, fb_clk_i = 0, reg_wr_i = 0, reg_rd_i = 0, locked_tb = 1;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0]  reg_wdata_i = 8'h00, rd_val;
    wire  [7:0]  reg_rdata_o;
    wire         status, pin_n, sticky, irq_n, fastlock;
    int          mismatches = 0, samples_checked = 0, in_cnt = 0, fb_cnt = 0, t;
    lock_loss_monitor #(.CNT_W(24), .SLOW_WIN_CYCLES(SLOW), .FAST_WIN_CYCLES(FAST)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .in_clk_i(in_clk_i), .fb_clk_i(fb_clk_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .lock_loss_status_o(status), .lock_loss_pin_n_o(pin_n), .lock_loss_sticky_o(sticky),
        .interrupt_out_n_o(irq_n), .fastlock_req_o(fastlock));
    always #12.5 clk_i = ~clk_i;
    // in: period 8 cycles; fb: period 10 cycles when unlocked
    always @(posedge clk_i) begin
        in_cnt <= (in_cnt == 3) ? 0 : in_cnt + 1;
        fb_cnt <= (fb_cnt == 4) ? 0 : fb_cnt + 1;
        if (in_cnt == 3) in_clk_i <= ~in_clk_i;
        if (locked_tb) fb_clk_i <= (in_cnt == 3) ? ~in_clk_i : in_clk_i;
        else if (fb_cnt == 4) fb_clk_i <= ~fb_clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1;
        @(posedge clk_i);
        reg_wr_i <= 0;
        #1;
    endtask
    task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1;
        @(posedge clk_i);
        reg_rd_i <= 0;
        #1 rd_val = reg_rdata_o;
        check(what, rd_val, e);
    endtask
    task automatic wait_status(input logic v, input int lim);
        t = 0;
        while (status !== v && t < lim) begin
            @(posedge clk_i);
            #1 t++;
        end
    endtask
    task automatic t_regs;
        check("pin after reset", pin_n, 1'b0);
        rchk("mask reset", `LM_ADDR_IRQ_MASK, 8'h00);
        rchk("fast enable reset", `LM_ADDR_FAST_ENABLE, 8'h02);
        rchk("timer enable reset", `LM_ADDR_TIMER_ENABLE, 8'h00);
        rchk("status after reset", `LM_ADDR_LIVE_STATUS, 8'h02);
        rchk("unmapped read", 16'h0100, 8'h00);
        for (int k = 0; k < 11; k++) begin
            if (k < 9) wr(`LM_ADDR_SET_THRESHOLD, 8'(k << 4));
            if (k < 9) rchk("set code", `LM_ADDR_SET_THRESHOLD, 8'(k << 4));
            wr(`LM_ADDR_CLEAR_THRESHOLD, 8'(k << 4));
            rchk("clear code", `LM_ADDR_CLEAR_THRESHOLD, 8'(k << 4));
        end
        wr(`LM_ADDR_SET_THRESHOLD, 8'h20);
        wr(`LM_ADDR_CLEAR_THRESHOLD, 8'h00);
        wr(`LM_ADDR_DELAY_BYTE3, 8'hFF);
        rchk("delay top bits", `LM_ADDR_DELAY_BYTE3, 8'h1F);
        wr(`LM_ADDR_DELAY_BYTE3, 8'h00);
        wr(`LM_ADDR_DELAY_BYTE0, 8'h08);
        rchk("delay low byte", `LM_ADDR_DELAY_BYTE0, 8'h08);
    endtask
    task automatic t_lock;
        wait_status(0, 3 * SLOW);
        check("lock gained in time", t <= 2 * SLOW + 16, 1'b1);
        check("pin when locked", pin_n, 1'b1);
        check("fastlock when locked", fastlock, 1'b0);
        wr(`LM_ADDR_STICKY_FLAG, 8'h02);
        check("sticky kept on write one", sticky, 1'b1);
        wr(`LM_ADDR_STICKY_FLAG, 8'h00);
        check("sticky cleared", sticky, 1'b0);
        check("irq released", irq_n, 1'b1);
    endtask
    task automatic t_fast_loss;
        locked_tb = 0;
        wait_status(1, 4 * FAST);
        check("fast loss time", t <= 2 * FAST + 16, 1'b1);
        check("sticky on loss", sticky, 1'b1);
        check("irq on loss", irq_n, 1'b0);
        wr(`LM_ADDR_STICKY_FLAG, 8'h00);
        check("clear refused while lost", sticky, 1'b1);
        wr(`LM_ADDR_IRQ_MASK, 8'h02);
        @(posedge clk_i);
        #1 check("irq masked", irq_n, 1'b1);
        wr(`LM_ADDR_IRQ_MASK, 8'h00);
        @(posedge clk_i);
        #1 check("irq unmasked", irq_n, 1'b0);
    endtask
    task automatic t_slow_and_timer;
        wr(`LM_ADDR_FAST_ENABLE, 8'h00);
        locked_tb = 1;
        wait_status(0, 3 * SLOW);
        // unlock for half a window only: the relock glitch stays inside the failing window
        locked_tb = 0;
        wr(`LM_ADDR_TIMER_ENABLE, 8'h02);
        repeat (SLOW / 2) @(posedge clk_i);
        #1 locked_tb = 1;
        wait_status(1, 2 * SLOW);
        check("slow loss only", t > 2 * FAST + 16 && t <= SLOW + 16, 1'b1);
        wait_status(0, 2 * SLOW + 4096);
        check("clear delay applied", t >= SLOW + 2040 && t <= SLOW + 2048 + 24, 1'b1);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_lock();
        t_fast_loss();
        t_slow_and_timer();
        end_of_test();
    end
    initial begin
        #1500000;
        mismatches++;
        end_of_test();
    end
endmodule // lock_loss_monitor_bench
`default_nettype wire
